/* include/tpc_consts.svh */
`ifndef TPC_CONSTS_SVH
`define TPC_CONSTS_SVH

// register width and word index of each register (byte address is four times the index)
`define TPC_REG_W          24
`define TPC_IDX_MODE       8'h40
`define TPC_IDX_XTALK      8'h41
`define TPC_IDX_OFF_MAIN   8'h42
`define TPC_IDX_CTRL       8'h43
`define TPC_IDX_OFF_ALIAS  8'h44
`define TPC_IDX_STATUS     8'h50

// reset values
`define TPC_RST_XTALK      24'h00_0010
`define TPC_RST_OFF        24'h00_0000
`define TPC_RST_CTRL       24'h00_0081
`define TPC_RST_MODE       24'h00_0000

// writable bits of each register; reserved bits are never stored and read zero
`define TPC_MASK_XTALK     24'hFF_FFFF
`define TPC_MASK_OFF       24'h00_FFFF
`define TPC_MASK_CTRL      24'hFF_F1C3
`define TPC_MASK_MODE      24'h00_0001

// field positions
`define TPC_TEMP_MSB       23
`define TPC_TEMP_LSB       12
`define TPC_BETA_MSB       11
`define TPC_BETA_LSB       6
`define TPC_ALPHA_MSB      5
`define TPC_ALPHA_LSB      0
`define TPC_OFF_MSB        15
`define TPC_OFF_LSB        0
`define TPC_SCALER_MSB     8
`define TPC_SCALER_LSB     6
`define TPC_TEMP_EN_BIT    1
`define TPC_OFFS_EN_BIT    0
`define TPC_MODE_BIT       0

// unity scaling in sixteenths, and zero scaling
`define TPC_XTALK_UNITY    6'h10
`define TPC_XTALK_ZERO     6'h00

// ahb-lite encodings
`define TPC_HTRANS_NONSEQ  2'h2
`define TPC_HRESP_OKAY     1'h0

`endif

/* include/tpc_pkg.sv */
package tpc_pkg;

    // register selected by a bus address
    typedef enum logic [2:0] {
        sel_none      = 3'b000,
        sel_xtalk     = 3'b001,
        sel_off_main  = 3'b010,
        sel_ctrl      = 3'b011,
        sel_off_alias = 3'b100,
        sel_mode      = 3'b101,
        sel_status    = 3'b110
    } tpc_regsel_type;

endpackage

/* rtl/tpc_phase_corr.sv */
`timescale 1ns/1ns
`include "tpc_consts.svh"

// subtracts the stored phase offset from each measured phase sample
module tpc_phase_corr
    import tpc_pkg::*;
#(
    parameter int PHASE_W = 16
) (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic [PHASE_W-1:0] meas_phase,
    input  wire logic               meas_valid,
    input  wire logic               meas_alias_freq,
    input  wire logic               alias_mode_on,
    input  wire logic               offset_on,
    input  wire logic [PHASE_W-1:0] off_main,
    input  wire logic [PHASE_W-1:0] off_alias,
    output logic      [PHASE_W-1:0] corr_phase_ff,
    output logic                    corr_valid_ff
);

    logic [PHASE_W-1:0] nxt_offset;   // offset chosen for this sample

    // alias offset only for alias-frequency samples while alias mode is on
    always_comb begin
        if (meas_alias_freq && alias_mode_on) begin
            nxt_offset = off_alias;
        end else begin
            nxt_offset = off_main;
        end
    end

    // corrected phase wraps modulo the phase range
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            corr_phase_ff <= '0;
        end else if (meas_valid) begin
            corr_phase_ff <= offset_on ? (meas_phase - nxt_offset) : meas_phase;
        end
    end

    // one-cycle valid beside each result
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            corr_valid_ff <= 1'b0;
        end else begin
            corr_valid_ff <= meas_valid;
        end
    end

    // offset subtracted exactly when enabled
    phase_subtract_a: assert property (@(posedge hclk) disable iff (!hresetn)
        meas_valid && offset_on && !(meas_alias_freq && alias_mode_on)
        |=> corr_phase_ff == $past(meas_phase) - $past(off_main))
        else $error("main offset not subtracted");

    alias_offset_a: assert property (@(posedge hclk) disable iff (!hresetn)
        meas_valid && offset_on && meas_alias_freq && alias_mode_on
        |=> corr_phase_ff == $past(meas_phase) - $past(off_alias))
        else $error("alias offset not subtracted");

    offset_bypass_a: assert property (@(posedge hclk) disable iff (!hresetn)
        meas_valid && !offset_on |=> corr_phase_ff == $past(meas_phase))
        else $error("phase changed with correction off");

endmodule

/* rtl/tpc_regs.sv */
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ns
`include "tpc_consts.svh"

// What this block does
// - beta field 11:6 means value over sixteen
// - alpha field 5:0 over sixteen, reset unity
// - hold on-chip sensor calibration temperature 23:12
// - hold external sensor calibration temperature 23:12
// - store primary-frequency phase offset 15:0
// - store alias-frequency phase offset 15:0
// - temperature correction only when bit 1 set
// - subtract offset only while bit 0 set
// - bits 8:6 scale temperature coefficients, reset 2
// - alias scaling and offset only in alias mode
module tpc_regs
    import tpc_pkg::*;
#(
    parameter int PHASE_W = 16
) (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    // ahb-lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic               hready,
    input  wire logic [31:0]        hwdata,
    output logic      [31:0]        hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    // phase samples from the measurement pipeline
    input  wire logic [PHASE_W-1:0] meas_phase,
    input  wire logic               meas_valid,
    input  wire logic               meas_alias_freq,
    // corrected phase
    output logic      [PHASE_W-1:0] corr_phase,
    output logic                    corr_valid,
    // configuration to the datapath
    output logic      [5:0]         illum_xtalk_quad_scale_alias_freq,
    output logic      [5:0]         illum_xtalk_inphase_scale_alias_freq,
    output logic      [11:0]        onchip_sensor_cal_temp_ch1_high,
    output logic      [11:0]        external_sensor_cal_temp_ch1_high,
    output logic      [2:0]         temp_coeff_scaler,
    output logic                    temp_correction_on,
    output logic                    alias_resolve_mode_on
);

    // register storage, reserved bits never set
    logic [`TPC_REG_W-1:0] xtalk_ff;        // cal temp and alias crosstalk scales
    logic [`TPC_REG_W-1:0] off_main_ff;     // primary frequency phase offset
    logic [`TPC_REG_W-1:0] ctrl_ff;         // correction control
    logic [`TPC_REG_W-1:0] off_alias_ff;    // alias frequency phase offset
    logic [`TPC_REG_W-1:0] mode_ff;         // alias resolve mode

    // bus state
    logic                  dp_write_ff;     // data phase of a write pending
    tpc_regsel_type        dp_sel_ff;       // register of the pending write
    logic [31:0]           hrdata_ff;       // read data
    logic                  hreadyout_ff;    // always ready, no wait states
    logic                  hresp_ff;        // always okay

    // registered outputs
    logic [5:0]            xt_beta_ff;      // effective beta in sixteenths
    logic [5:0]            xt_alpha_ff;     // effective alpha in sixteenths
    logic [11:0]           temp_main_ff;    // on-chip cal temperature
    logic [11:0]           temp_ext_ff;     // external cal temperature
    logic [2:0]            scaler_ff;       // temperature coefficient scaler
    logic                  temp_on_ff;      // temperature correction active
    logic                  mode_on_ff;      // alias mode active

    // address phase decode
    logic                  addr_take;       // valid transfer taken this edge
    tpc_regsel_type        addr_sel;        // register it addresses
    logic [`TPC_REG_W-1:0] wr_value;        // write data with reserved bits cleared
    logic [`TPC_REG_W-1:0] nxt_rd_value;    // data for a read taken now
    logic [PHASE_W-1:0]    corr_phase_w;    // from the correction unit
    logic                  corr_valid_w;    // from the correction unit

    // word index from a byte address; anything off the map selects nothing
    function automatic tpc_regsel_type decode_addr(input logic [31:0] addr);
        tpc_regsel_type s;
        s = sel_none;
        if (addr[31:10] == 22'h00_0000) begin
            case (addr[9:2])
                `TPC_IDX_XTALK:     s = sel_xtalk;
                `TPC_IDX_OFF_MAIN:  s = sel_off_main;
                `TPC_IDX_CTRL:      s = sel_ctrl;
                `TPC_IDX_OFF_ALIAS: s = sel_off_alias;
                `TPC_IDX_MODE:      s = sel_mode;
                `TPC_IDX_STATUS:    s = sel_status;
                default:            s = sel_none;
            endcase
        end
        return s;
    endfunction

    // writable bits of a register
    function automatic logic [`TPC_REG_W-1:0] reg_mask(input tpc_regsel_type s);
        logic [`TPC_REG_W-1:0] m;
        m = '0;
        case (s)
            sel_xtalk:     m = `TPC_MASK_XTALK;
            sel_off_main:  m = `TPC_MASK_OFF;
            sel_ctrl:      m = `TPC_MASK_CTRL;
            sel_off_alias: m = `TPC_MASK_OFF;
            sel_mode:      m = `TPC_MASK_MODE;
            default:       m = '0;
        endcase
        return m;
    endfunction

    assign addr_take = hsel && hready && (htrans == `TPC_HTRANS_NONSEQ);
    assign addr_sel  = decode_addr(haddr);
    assign wr_value  = hwdata[`TPC_REG_W-1:0] & reg_mask(dp_sel_ff);

    // read mux; a write completing this edge is forwarded to a read taken now
    always_comb begin
        case (addr_sel)
            sel_xtalk:     nxt_rd_value = xtalk_ff;
            sel_off_main:  nxt_rd_value = off_main_ff;
            sel_ctrl:      nxt_rd_value = ctrl_ff;
            sel_off_alias: nxt_rd_value = off_alias_ff;
            sel_mode:      nxt_rd_value = mode_ff;
            sel_status:    nxt_rd_value = {{(`TPC_REG_W-PHASE_W){1'b0}}, corr_phase_w};
            default:       nxt_rd_value = '0;
        endcase
        if (dp_write_ff && dp_sel_ff == addr_sel && addr_sel != sel_status) begin
            nxt_rd_value = wr_value;
        end
    end

    // data phase tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write_ff <= 1'b0;
            dp_sel_ff   <= sel_none;
        end else if (hready) begin
            dp_write_ff <= addr_take && hwrite;
            dp_sel_ff   <= addr_sel;
        end
    end

    // read data loaded at the address phase edge, held through the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (addr_take && !hwrite) begin
            hrdata_ff <= {{(32-`TPC_REG_W){1'b0}}, nxt_rd_value};
        end
    end

    // zero wait states and okay response
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_ff <= 1'b1;
            hresp_ff     <= `TPC_HRESP_OKAY;
        end else begin
            hreadyout_ff <= 1'b1;
            hresp_ff     <= `TPC_HRESP_OKAY;
        end
    end

    // register writes: whole word at once, only from the bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xtalk_ff     <= `TPC_RST_XTALK;
            off_main_ff  <= `TPC_RST_OFF;
            ctrl_ff      <= `TPC_RST_CTRL;
            off_alias_ff <= `TPC_RST_OFF;
            mode_ff      <= `TPC_RST_MODE;
        end else if (dp_write_ff) begin
            case (dp_sel_ff)
                sel_xtalk:     xtalk_ff     <= wr_value;
                sel_off_main:  off_main_ff  <= wr_value;
                sel_ctrl:      ctrl_ff      <= wr_value;
                sel_off_alias: off_alias_ff <= wr_value;
                sel_mode:      mode_ff      <= wr_value;
                default:       ;
            endcase
        end
    end

    // crosstalk scales in sixteenths; unity alpha and zero beta outside alias mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xt_beta_ff  <= `TPC_XTALK_ZERO;
            xt_alpha_ff <= `TPC_XTALK_UNITY;
        end else if (mode_ff[`TPC_MODE_BIT]) begin
            xt_beta_ff  <= xtalk_ff[`TPC_BETA_MSB:`TPC_BETA_LSB];
            xt_alpha_ff <= xtalk_ff[`TPC_ALPHA_MSB:`TPC_ALPHA_LSB];
        end else begin
            xt_beta_ff  <= `TPC_XTALK_ZERO;
            xt_alpha_ff <= `TPC_XTALK_UNITY;
        end
    end

    // temperature correction and alias mode settings to the datapath
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            temp_main_ff <= '0;
            temp_ext_ff  <= '0;
            scaler_ff    <= '0;
            temp_on_ff   <= 1'b0;
            mode_on_ff   <= 1'b0;
        end else begin
            temp_main_ff <= xtalk_ff[`TPC_TEMP_MSB:`TPC_TEMP_LSB];
            temp_ext_ff  <= ctrl_ff[`TPC_TEMP_MSB:`TPC_TEMP_LSB];
            scaler_ff    <= ctrl_ff[`TPC_SCALER_MSB:`TPC_SCALER_LSB];
            temp_on_ff   <= ctrl_ff[`TPC_TEMP_EN_BIT];
            mode_on_ff   <= mode_ff[`TPC_MODE_BIT];
        end
    end

    // phase offset subtraction
    tpc_phase_corr #(
        .PHASE_W (PHASE_W)
    ) u_corr (
        .hclk            (hclk),
        .hresetn         (hresetn),
        .meas_phase      (meas_phase),
        .meas_valid      (meas_valid),
        .meas_alias_freq (meas_alias_freq),
        .alias_mode_on   (mode_ff[`TPC_MODE_BIT]),
        .offset_on       (ctrl_ff[`TPC_OFFS_EN_BIT]),
        .off_main        (off_main_ff[`TPC_OFF_MSB:`TPC_OFF_LSB]),
        .off_alias       (off_alias_ff[`TPC_OFF_MSB:`TPC_OFF_LSB]),
        .corr_phase_ff   (corr_phase_w),
        .corr_valid_ff   (corr_valid_w)
    );

    // outputs
    assign hrdata                               = hrdata_ff;
    assign hreadyout                            = hreadyout_ff;
    assign hresp                                = hresp_ff;
    assign corr_phase                           = corr_phase_w;
    assign corr_valid                           = corr_valid_w;
    assign illum_xtalk_quad_scale_alias_freq    = xt_beta_ff;
    assign illum_xtalk_inphase_scale_alias_freq = xt_alpha_ff;
    assign onchip_sensor_cal_temp_ch1_high      = temp_main_ff;
    assign external_sensor_cal_temp_ch1_high    = temp_ext_ff;
    assign temp_coeff_scaler                    = scaler_ff;
    assign temp_correction_on                   = temp_on_ff;
    assign alias_resolve_mode_on                = mode_on_ff;

    // beta follows the field one edge later in alias mode
    beta_field_a: assert property (@(posedge hclk) disable iff (!hresetn)
        mode_ff[`TPC_MODE_BIT] |=> xt_beta_ff == $past(xtalk_ff[11:6]))
        else $error("beta scale does not follow its field");

    alpha_unity_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !mode_ff[`TPC_MODE_BIT] |=> xt_alpha_ff == 6'h10 && xt_beta_ff == 6'h00)
        else $error("alias scaling used outside alias mode");

    alpha_field_a: assert property (@(posedge hclk) disable iff (!hresetn)
        mode_ff[`TPC_MODE_BIT] |=> xt_alpha_ff == $past(xtalk_ff[5:0]))
        else $error("alpha scale does not follow its field");

    main_temp_a: assert property (@(posedge hclk) disable iff (!hresetn)
        dp_write_ff && dp_sel_ff == sel_xtalk
        |=> ##1 temp_main_ff == $past(hwdata[23:12], 2))
        else $error("on-chip calibration temperature wrong");

    ext_temp_a: assert property (@(posedge hclk) disable iff (!hresetn)
        dp_write_ff && dp_sel_ff == sel_ctrl
        |=> ##1 temp_ext_ff == $past(hwdata[23:12], 2) && scaler_ff == $past(hwdata[8:6], 2))
        else $error("external temperature or scaler wrong");

    temp_enable_a: assert property (@(posedge hclk) disable iff (!hresetn)
        temp_on_ff == $past(ctrl_ff[1]))
        else $error("temperature correction enable mismatch");

    main_offset_a: assert property (@(posedge hclk) disable iff (!hresetn)
        dp_write_ff && dp_sel_ff == sel_off_main
        |=> off_main_ff == {8'h00, $past(hwdata[15:0])})
        else $error("primary offset write wrong");

    alias_store_a: assert property (@(posedge hclk) disable iff (!hresetn)
        dp_write_ff && dp_sel_ff == sel_off_alias
        |=> off_alias_ff == {8'h00, $past(hwdata[15:0])})
        else $error("alias offset write wrong");

    ctrl_reserved_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_ff[11:9] == 3'h0 && ctrl_ff[5:2] == 4'h0)
        else $error("reserved control bits set");

    regs_stable_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !dp_write_ff |=> $stable(xtalk_ff) && $stable(ctrl_ff) && $stable(off_main_ff))
        else $error("register changed without a write");

    // main scenarios
    cov_ctrl_write: cover property (@(posedge hclk) disable iff (!hresetn)
        dp_write_ff && dp_sel_ff == sel_ctrl);
    cov_alias_sample: cover property (@(posedge hclk) disable iff (!hresetn)
        meas_valid && meas_alias_freq && mode_ff[`TPC_MODE_BIT]);
    cov_fwd_read: cover property (@(posedge hclk) disable iff (!hresetn)
        dp_write_ff && addr_take && !hwrite && dp_sel_ff == addr_sel);

endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ns
`include "tpc_consts.svh"

// self-checking bench for the calibration register bank and its offset path
module tb_top;
    import tpc_pkg::*;

    logic        hclk;              // bus clock, 25 MHz
    logic        hresetn;           // async reset, active low
    logic        hsel;              // slave select
    logic [31:0] haddr;             // byte address
    logic [1:0]  htrans;            // transfer type
    logic        hwrite;            // write strobe
    logic [2:0]  hsize;             // transfer size
    logic [31:0] hwdata;            // write data
    logic [31:0] hrdata;            // read data
    logic        hreadyout;         // slave ready, fed back as bus ready
    logic        hresp;             // slave response
    logic [15:0] meas_phase;        // measured phase sample
    logic        meas_valid;        // sample strobe
    logic        meas_alias_freq;   // sample taken at the alias frequency
    logic [15:0] corr_phase;        // corrected phase
    logic        corr_valid;        // corrected phase strobe
    logic [5:0]  beta;              // effective quadrature scale
    logic [5:0]  alpha;             // effective in-phase scale
    logic [11:0] t_chip;            // on-chip sensor calibration temperature
    logic [11:0] t_ext;             // external sensor calibration temperature
    logic [2:0]  scaler;            // temperature coefficient scaler
    logic        temp_on;           // temperature correction enable
    logic        mode_on;           // alias resolve mode
    int          n_mismatch;        // mismatches seen
    int          n_tests;           // comparisons made
    logic [31:0] rdv;               // last read value

    // one table row: address, value written, value read back
    typedef struct {
        logic [31:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } tpc_row_type;
    tpc_row_type rows [6];

    tpc_regs tpc_regs_i (
        .hclk (hclk), .hresetn (hresetn), .hsel (hsel), .haddr (haddr),
        .htrans (htrans), .hwrite (hwrite), .hsize (hsize), .hready (hreadyout),
        .hwdata (hwdata), .hrdata (hrdata), .hreadyout (hreadyout), .hresp (hresp),
        .meas_phase (meas_phase), .meas_valid (meas_valid),
        .meas_alias_freq (meas_alias_freq), .corr_phase (corr_phase),
        .corr_valid (corr_valid), .illum_xtalk_quad_scale_alias_freq (beta),
        .illum_xtalk_inphase_scale_alias_freq (alpha),
        .onchip_sensor_cal_temp_ch1_high (t_chip),
        .external_sensor_cal_temp_ch1_high (t_ext), .temp_coeff_scaler (scaler),
        .temp_correction_on (temp_on), .alias_resolve_mode_on (mode_on)
    );

    // clock generator
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // prints the counts and the verdict, then stops
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // one comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    // waits for an edge with ready high, bounded
    task automatic wait_rdy;
        int i;
        for (i = 0; i < 16; i++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) break;
        end
        if (i == 16) begin
            n_mismatch++;
            results();
        end
    endtask

    // single word transfer: address phase, then data phase
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= `TPC_HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= wr;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rdv = hrdata;
    endtask

    // read and compare
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0000_0000);
        chk(rdv, e);
    endtask

    // write then read of one register back to back, read takes the fresh value
    task automatic wr_rd(input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= `TPC_HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= 1'b1;
        wait_rdy();
        hwrite <= 1'b0;
        hwdata <= d;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        wait_rdy();
        chk(hrdata, e);
    endtask

    // lets a register write reach the config outputs
    task automatic settle;
        repeat (2) @(posedge hclk);
        #1;
    endtask

    // one phase sample and its corrected result
    task automatic ph(input logic [15:0] p, input logic af, input logic [15:0] e);
        @(posedge hclk);
        meas_phase      <= p;
        meas_valid      <= 1'b1;
        meas_alias_freq <= af;
        @(posedge hclk);
        meas_valid <= 1'b0;
        #1;
        chk({31'h0, corr_valid}, 32'h0000_0001);
        chk({16'h0, corr_phase}, {16'h0, e});
    endtask

    // hang guard
    initial begin
        repeat (100000) @(posedge hclk);
        n_mismatch++;
        results();
    end

    // main sequence
    initial begin
        n_mismatch = 0;
        n_tests = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        meas_phase = 16'h0000;
        meas_valid = 1'b0;
        meas_alias_freq = 1'b0;
        rows[0] = '{32'h0000_0104, 32'hFFAB_CDEF, 32'h00AB_CDEF};
        rows[1] = '{32'h0000_0108, 32'h00FF_1234, 32'h0000_1234};
        rows[2] = '{32'h0000_010C, 32'h0012_3E7F, 32'h0012_3043};
        rows[3] = '{32'h0000_0110, 32'h0055_8001, 32'h0000_8001};
        rows[4] = '{32'h0000_0100, 32'h0000_0003, 32'h0000_0001};
        rows[5] = '{32'h0000_0200, 32'hFFFF_FFFF, 32'h0000_0000};
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        settle();
        // reset values of registers and config outputs
        rd_chk(32'h0000_0100, 32'h0000_0000);
        rd_chk(32'h0000_0104, 32'h0000_0010);
        rd_chk(32'h0000_0108, 32'h0000_0000);
        rd_chk(32'h0000_010C, 32'h0000_0081);
        rd_chk(32'h0000_0110, 32'h0000_0000);
        chk({29'h0, scaler}, 32'h0000_0002);
        chk({31'h0, temp_on}, 32'h0000_0000);
        chk({26'h0, alpha}, 32'h0000_0010);
        chk({26'h0, beta}, 32'h0000_0000);
        // table: write then read back, reserved bits drop to zero
        foreach (rows[k]) begin
            ahb(1'b1, rows[k].a, rows[k].d);
            rd_chk(rows[k].a, rows[k].e);
        end
        settle();
        chk({20'h0, t_chip}, 32'h0000_0ABC);
        chk({20'h0, t_ext}, 32'h0000_0123);
        chk({26'h0, beta}, 32'h0000_0037);
        chk({26'h0, alpha}, 32'h0000_002F);
        chk({29'h0, scaler}, 32'h0000_0001);
        chk({31'h0, temp_on}, 32'h0000_0001);
        chk({31'h0, mode_on}, 32'h0000_0001);
        // alias mode off forces unity alpha and zero beta
        ahb(1'b1, 32'h0000_0100, 32'h0000_0000);
        settle();
        chk({26'h0, alpha}, 32'h0000_0010);
        chk({26'h0, beta}, 32'h0000_0000);
        // offset subtraction, primary and alias frequency
        ahb(1'b1, 32'h0000_0108, 32'h0000_0100);
        ahb(1'b1, 32'h0000_0110, 32'h0000_0040);
        ahb(1'b1, 32'h0000_010C, 32'h0000_0081);
        ph(16'h0050, 1'b1, 16'hFF50);
        ahb(1'b1, 32'h0000_0100, 32'h0000_0001);
        ph(16'h0050, 1'b0, 16'hFF50);
        ph(16'h0050, 1'b1, 16'h0010);
        // back-to-back samples
        @(posedge hclk);
        meas_phase <= 16'h1000;
        meas_valid <= 1'b1;
        meas_alias_freq <= 1'b0;
        @(posedge hclk);
        meas_alias_freq <= 1'b1;
        #1;
        chk({16'h0, corr_phase}, 32'h0000_0F00);
        @(posedge hclk);
        meas_valid <= 1'b0;
        #1;
        chk({16'h0, corr_phase}, 32'h0000_0FC0);
        chk({31'h0, corr_valid}, 32'h0000_0001);
        // offset correction off passes the phase through
        ahb(1'b1, 32'h0000_010C, 32'h0000_0080);
        ph(16'h1234, 1'b0, 16'h1234);
        settle();
        chk({31'h0, temp_on}, 32'h0000_0000);
        // values kept across samples
        rd_chk(32'h0000_0108, 32'h0000_0100);
        rd_chk(32'h0000_0110, 32'h0000_0040);
        wr_rd(32'h0000_0108, 32'h0012_5678, 32'h0000_5678);
        // second reset in mid-run
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(32'h0000_010C, 32'h0000_0081);
        rd_chk(32'h0000_0108, 32'h0000_0000);
        rd_chk(32'h0000_0104, 32'h0000_0010);
        chk({29'h0, scaler}, 32'h0000_0002);
        chk({31'h0, temp_on}, 32'h0000_0000);
        results();
    end
endmodule
